// ===== sim/msc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host CPU on the register port
// ----------------------------------------
module msc_host_model (
  input  wire logic [0:0]  clk,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        io_ready
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // One-cycle write; lines scrambled once released
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask
  // One-cycle read; ready seen in the strobe cycle, data in the next
  task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic r);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    #1 r = io_ready;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== sim/msc_regs_tb_top.sv
`include "msc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module msc_regs_tb_top;
  // ----------------------------------------
  // Signals, design and host
  // ----------------------------------------
  localparam int EXC = 20;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic        reg_wr, reg_rd, io_ready, rdy;
  logic data_reg_busy, tx_frame_start, tx_frame_end, tx_multicast, tx_collision, tx_fatal;
  logic tx_enable_set, tx_deferring, tx_in_gap, carrier_sense, rx_byte, rx_frame_end;
  logic rx_dest_group, rx_dest_match, rx_mcast_match, rx_own_frame, full_duplex;
  logic mmu_reset, mem_alloc, mem_release, rx_alloc_req, irq_event;
  logic rx_alloc_ok, rx_accept, rx_frame_drop, rx_carrier, crc_strip, counter_rollover;
  logic soft_reset_active, mii_select_pin, full_step_pin_n, attachment_select_pin;
  logic [3:0]  interrupt_out, interrupt_out_oe;
  int          err_total = 0;
  int          num_checks = 0;
  msc_regs #(.EXCESSIVE_DEFERRAL_FLAG_CYCLES(EXC)) dut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_ready,
    .data_reg_busy, .tx_frame_start, .tx_frame_end, .tx_multicast, .tx_collision,
    .tx_fatal, .tx_enable_set, .tx_deferring, .tx_in_gap, .carrier_sense, .rx_byte,
    .rx_frame_end, .rx_dest_group, .rx_dest_match, .rx_mcast_match, .rx_own_frame,
    .full_duplex, .mmu_reset, .mem_alloc, .mem_release, .rx_alloc_req, .irq_event,
    .rx_alloc_ok, .rx_accept, .rx_frame_drop, .rx_carrier, .crc_strip, .counter_rollover,
    .soft_reset_active, .mii_select_pin, .full_step_pin_n, .attachment_select_pin,
    .interrupt_out, .interrupt_out_oe
  );
  msc_host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_ready);
  // Clock
  always #4 clk = ~clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Masked register read compare
  task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    host.rd(a, d, rdy);
    chk(d & m, e);
  endtask
  // Let edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Transmit frame with collisions and an optional deferral stretch
  task automatic frame(input int nc, input logic mc, input logic fat, input int dly);
    @(posedge clk);
    tx_frame_start <= 1'b1;
    @(posedge clk);
    tx_frame_start <= 1'b0;
    {tx_deferring, tx_in_gap, carrier_sense} <= {3{dly > 0}};
    repeat (dly) @(posedge clk);
    {tx_deferring, tx_in_gap, carrier_sense} <= 3'b000;
    repeat (nc) begin
      @(posedge clk);
      tx_collision <= 1'b1;
      @(posedge clk);
      tx_collision <= 1'b0;
    end
    @(posedge clk);
    {tx_multicast, tx_fatal, tx_frame_end} <= {mc, fat, 1'b1};
    @(posedge clk);
    tx_frame_end <= 1'b0;
  endtask
  // Received frame of n bytes
  task automatic rxf(input int n);
    @(posedge clk);
    rx_byte <= 1'b1;
    repeat (n) @(posedge clk);
    {rx_byte, rx_frame_end} <= 2'b01;
    @(posedge clk);
    rx_frame_end <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rc(`MSC_ADDR_CFG, 16'h9506, 16'h8000);
    chk(16'(rdy), 16'h0);
    rc(`MSC_ADDR_TXST, 16'hffff, 16'h0000);
    rc(`MSC_ADDR_RXCTL, 16'hffff, 16'h0000);
    rc(`MSC_ADDR_STAT, 16'hffff, 16'h0000);
    rc(`MSC_ADDR_MEMINFO, 16'hffff, 16'hffff);
    rc(`MSC_ADDR_MEMCFG, 16'h0eff, 16'h0400);
    rc(8'h30, 16'hffff, 16'h0000);
    chk(16'({mii_select_pin, full_step_pin_n, attachment_select_pin}), 16'h6);
  endtask
  // Interrupt routing, output pins, no-wait
  task automatic t_cfg();
    for (int i = 0; i < 4; i++) begin
      host.wr(`MSC_ADDR_CFG, 16'h1500 | 16'(i << 1));
      rc(`MSC_ADDR_CFG, 16'h9506, 16'h1500 | 16'(i << 1));
      chk(16'(interrupt_out_oe), 16'(1 << i));
      chk(16'(interrupt_out & interrupt_out_oe), 16'(1 << i));
    end
    chk(16'(rdy), 16'h1);
    chk(16'({mii_select_pin, full_step_pin_n, attachment_select_pin}), 16'h1);
  endtask
  task automatic t_tx();
    frame(1, 1'b1, 1'b0, 0);
    rc(`MSC_ADDR_TXST, 16'h000b, 16'h000b);
    rc(`MSC_ADDR_STAT, 16'hffff, 16'h0001);
    rc(`MSC_ADDR_STAT, 16'hffff, 16'h0000);
    frame(0, 1'b0, 1'b0, 0);
    rc(`MSC_ADDR_TXST, 16'h0006, 16'h0000);
    frame(2, 1'b0, 1'b0, 0);
    rc(`MSC_ADDR_TXST, 16'h000d, 16'h0005);
    rc(`MSC_ADDR_STAT, 16'hffff, 16'h0010);
    frame(16, 1'b0, 1'b1, 0);
    rc(`MSC_ADDR_TXST, 16'h0001, 16'h0000);
    host.rd(`MSC_ADDR_STAT, d, rdy);
    frame(0, 1'b0, 1'b0, 0);
    @(posedge clk);
    tx_enable_set <= 1'b1;
    @(posedge clk);
    tx_enable_set <= 1'b0;
    rc(`MSC_ADDR_TXST, 16'h0001, 16'h0000);
    frame(0, 1'b0, 1'b0, EXC + 5);
    rc(`MSC_ADDR_STAT, 16'hff00, 16'h1100);
    repeat (17) frame(1, 1'b0, 1'b0, 0);
    tick(1);
    chk(16'(counter_rollover), 16'h1);
    rc(`MSC_ADDR_STAT, 16'hffff, 16'h000f);
    tick(1);
    chk(16'(counter_rollover), 16'h0);
  endtask
  // Address filter, CRC strip, oversize abort
  task automatic t_rx();
    @(posedge clk);
    carrier_sense <= 1'b1;
    host.wr(`MSC_ADDR_RXCTL, 16'h0316);
    tick(3);
    chk(16'({crc_strip, rx_accept}), 16'h3);
    @(posedge clk);
    rx_own_frame <= 1'b1;
    tick(1);
    chk(16'(rx_accept), 16'h0);
    host.wr(`MSC_ADDR_RXCTL, 16'h0110);
    {rx_own_frame, rx_dest_group} <= 2'b01;
    tick(1);
    chk(16'({crc_strip, rx_accept}), 16'h1);
    host.wr(`MSC_ADDR_RXCTL, 16'h0100);
    tick(1);
    chk(16'(rx_accept), 16'h0);
    rxf(2044);
    rc(`MSC_ADDR_RXCTL, 16'h0002, 16'h0000);
    rxf(2045);
    tick(0);
    chk(16'(rx_frame_drop), 16'h1);
    rc(`MSC_ADDR_RXCTL, 16'h0002, 16'h0002);
    host.wr(`MSC_ADDR_RXCTL, 16'h0100);
    rc(`MSC_ADDR_RXCTL, 16'h0002, 16'h0000);
    @(posedge clk);
    carrier_sense <= 1'b0;
    tick(4);
  endtask
  // Leading edge of carrier held back only when filtering
  task automatic t_filt(input logic f);
    host.wr(`MSC_ADDR_RXCTL, {1'b0, f, 14'h0100});
    @(posedge clk);
    carrier_sense <= 1'b1;
    tick(4);
    chk(16'(rx_carrier), 16'(!f));
    tick(6);
    chk(16'(rx_carrier), 16'h1);
    @(posedge clk);
    carrier_sense <= 1'b0;
    tick(8);
  endtask
  task automatic t_mem();
    repeat (2) begin
      @(posedge clk);
      mem_alloc <= 1'b1;
      @(posedge clk);
      mem_alloc <= 1'b0;
    end
    rc(`MSC_ADDR_MEMINFO, 16'h00ff, 16'h00fd);
    host.wr(`MSC_ADDR_MEMCFG, 16'h0afd);
    rx_alloc_req <= 1'b1;
    tick(1);
    chk(16'(rx_alloc_ok), 16'h0);
    host.wr(`MSC_ADDR_MEMCFG, 16'h00fc);
    tick(1);
    chk(16'(rx_alloc_ok), 16'h1);
    @(posedge clk);
    mmu_reset <= 1'b1;
    @(posedge clk);
    mmu_reset <= 1'b0;
    rc(`MSC_ADDR_MEMINFO, 16'hffff, 16'hffff);
    rc(`MSC_ADDR_MEMCFG, 16'h0eff, 16'h04fc);
  endtask
  // Software reset keeps configuration, clears reservation and CRC strip
  task automatic t_srst();
    host.wr(`MSC_ADDR_RXCTL, 16'h8316);
    tick(1);
    chk(16'(soft_reset_active), 16'h1);
    host.wr(`MSC_ADDR_RXCTL, 16'h0000);
    rc(`MSC_ADDR_CFG, 16'h9506, 16'h1506);
    rc(`MSC_ADDR_MEMCFG, 16'h00ff, 16'h0000);
    chk(16'({soft_reset_active, crc_strip}), 16'h0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {data_reg_busy, tx_frame_start, tx_frame_end, tx_multicast, tx_collision} = '0;
    {tx_fatal, tx_enable_set, tx_deferring, tx_in_gap, carrier_sense, rx_byte} = '0;
    {rx_frame_end, rx_dest_group, rx_dest_match, rx_mcast_match, rx_own_frame} = '0;
    {full_duplex, mmu_reset, mem_alloc, mem_release, rx_alloc_req} = '0;
    irq_event = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_cfg();
    t_tx();
    t_rx();
    t_filt(1'b0);
    t_filt(1'b1);
    t_mem();
    t_srst();
    test_done();
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire

// ===== src/msc_defines.svh
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH
// Register indices (byte address is four times the index)
`define MSC_IDX_CFG        8'h00
`define MSC_IDX_TXST       8'h02
`define MSC_IDX_RXCTL      8'h04
`define MSC_IDX_STAT       8'h06
`define MSC_IDX_MEMINFO    8'h08
`define MSC_IDX_MEMCFG     8'h0a
`define MSC_ADDR_CFG       8'h00
`define MSC_ADDR_TXST      8'h08
`define MSC_ADDR_RXCTL     8'h10
`define MSC_ADDR_STAT      8'h18
`define MSC_ADDR_MEMINFO   8'h20
`define MSC_ADDR_MEMCFG    8'h28
// Configuration fields
`define MSC_CFG_PORT_SEL   15
`define MSC_CFG_NO_WAIT    12
`define MSC_CFG_FULL_STEP  10
`define MSC_CFG_ATT_SEL    8
`define MSC_CFG_INT_LO     1
`define MSC_CFG_RST        16'ha0b0
`define MSC_CFG_WMASK      16'h9506
// Transmit status fields
`define MSC_TS_SUCCESS     0
`define MSC_TS_SNGL        1
`define MSC_TS_MULTI       2
`define MSC_TS_LAST_TX_MULTICAST    3
`define MSC_TS_EXCESSIVE_DEFERRAL_FLAG     6
`define MSC_TS_DEFR        7
// Receive control fields
`define MSC_RC_ABORT       1
`define MSC_RC_PROMISC     2
`define MSC_RC_ALLMULT     4
`define MSC_RC_RX_EN       8
`define MSC_RC_CRC_STRIP   9
`define MSC_RC_CAR_FILT    14
`define MSC_RC_SOFT_RST    15
`define MSC_RC_WMASK       16'hc316
// Memory
`define MSC_MEM_SIZE_RST   8'hff
`define MSC_MEM_MULT       3'h2
`define MSC_MAX_FRAME      12'h7fc
`define MSC_STAT_SAT       4'hf
// Timing
`define MSC_FILT_NIBBLES   2'h3
`define MSC_WAIT_CLKS      2'h2
`define MSC_CLK_NS         8
`define MSC_EXCESSIVE_DEFERRAL_FLAG_BYTES  (1518 * 2)
`define MSC_EXCESSIVE_DEFERRAL_FLAG_NS     (`MSC_EXCESSIVE_DEFERRAL_FLAG_BYTES * 800)
`define MSC_EXCESSIVE_DEFERRAL_FLAG_CYC    (`MSC_EXCESSIVE_DEFERRAL_FLAG_NS / `MSC_CLK_NS)
`define MSC_DEFER_NS       6400
`define MSC_DEFER_CYC      (`MSC_DEFER_NS / `MSC_CLK_NS)
`endif

// ===== src/msc_pkg.sv
package msc_pkg;
  typedef struct packed {
    logic [15:0] cfg;
    logic        ts_success;
    logic        ts_sngl;
    logic        ts_multi;
    logic        ts_mult;
    logic        ts_excessive_deferral_flag;
    logic        ts_defr;
    logic [15:0] rxctl;
    logic [3:0]  cnt_exc;
    logic [3:0]  cnt_def;
    logic [3:0]  cnt_mul;
    logic [3:0]  cnt_sgl;
    logic [7:0]  free_mem;
    logic [7:0]  tx_resv;
    logic [15:0] rdata;
    logic [1:0]  filt_cnt;
    logic        car_seen;
    logic        rx_active;
    logic        rx_drop;
    logic [11:0] rx_len;
    logic        sent_defer;
    logic        wait_on;
    logic [1:0]  wait_cnt;
    logic        gate_excess;
    logic [31:0] defer_cyc;
    logic        carrier_d;
  } msc_state_type;
endpackage

// ===== src/msc_regs.sv
// Notes on behaviour
// - Multicast flag set on multicast, cleared per frame
// - Multi-collision flag set, cleared at next frame start after success
// - Single-collision flag set, cleared at next frame start after success
// - Success flag unless fatal; cleared start/enable
// - Soft reset keeps configuration; only flags, counters, rxctl, memory and rx_active are cleared
// - Carrier filter delays carrier by three nibbles
// - CRC strip flag drops CRC from stores
// - Receive enable; current frame completes first
// - All-multicast accepts any group address
// - Promiscuous accepts all, not own unless duplex
// - Oversize frame dropped, sticky abort flag
// - Four saturating counters; read clears; event out
// - Counter nibble layout fixed, reset zero
// - Counters advance at most once per packet
// - Free memory readable, resets to size
// - Memory units, size reads FFh
// - Transmit reservation refuses receive allocations
// - Multiplier code in bits 11 to 9
// - Port select bit drives select pin
// - Ready held low unless no-wait
// - Full-step inverted, attach select direct
// - Interrupt routed to one of four pins
// - Excessive deferral beyond 3036 byte times
// - Deferral when carrier in first 6.4 us
//
// The address-and-strobe port was left to the implementer.
`include "msc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module msc_regs #(
  parameter int EXCESSIVE_DEFERRAL_FLAG_CYCLES = `MSC_EXCESSIVE_DEFERRAL_FLAG_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             io_ready,
  input  wire logic        data_reg_busy,
  input  wire logic        tx_frame_start,
  input  wire logic        tx_frame_end,
  input  wire logic        tx_multicast,
  input  wire logic        tx_collision,
  input  wire logic        tx_fatal,
  input  wire logic        tx_enable_set,
  input  wire logic        tx_deferring,
  input  wire logic        tx_in_gap,
  input  wire logic        carrier_sense,
  input  wire logic        rx_byte,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_dest_group,
  input  wire logic        rx_dest_match,
  input  wire logic        rx_mcast_match,
  input  wire logic        rx_own_frame,
  input  wire logic        full_duplex,
  input  wire logic        mmu_reset,
  input  wire logic        mem_alloc,
  input  wire logic        mem_release,
  input  wire logic        rx_alloc_req,
  input  wire logic        irq_event,
  output logic             rx_alloc_ok,
  output logic             rx_accept,
  output logic             rx_frame_drop,
  output logic             rx_carrier,
  output logic             crc_strip,
  output logic             counter_rollover,
  output logic             soft_reset_active,
  output logic             mii_select_pin,
  output logic             full_step_pin_n,
  output logic             attachment_select_pin,
  output logic [3:0]       interrupt_out,
  output logic [3:0]       interrupt_out_oe
);
  import msc_pkg::*;

  msc_state_type s_ff;
  msc_state_type nxt_s;
  logic [2:0]    col_cnt_ff;
  logic          carrier_m_ff;
  logic          carrier_s_ff;
  logic          soft_rst;
  logic          stat_rd;
  logic [15:0]   stat_word;

  // ---------------------------------------------------------------
  // Pin synchroniser for carrier
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    carrier_m_ff <= carrier_sense;
    carrier_s_ff <= carrier_m_ff;
  end

  // Collision count for the current frame
  always_ff @(posedge clk) begin
    if (sys_rst || tx_frame_start) begin
      col_cnt_ff <= 3'h0;
    end else if (tx_collision && col_cnt_ff != 3'h7) begin
      col_cnt_ff <= col_cnt_ff + 3'h1;
    end
  end

  assign soft_rst  = s_ff.rxctl[`MSC_RC_SOFT_RST];
  assign stat_rd   = reg_rd && reg_addr == `MSC_ADDR_STAT;
  assign stat_word = {s_ff.cnt_exc, s_ff.cnt_def, s_ff.cnt_mul, s_ff.cnt_sgl};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic ok_end;
    logic wr_cfg;
    logic wr_rx;
    logic wr_mem;
    ok_end = tx_frame_end && !tx_fatal;
    wr_cfg = reg_wr && reg_addr == `MSC_ADDR_CFG;
    wr_rx  = reg_wr && reg_addr == `MSC_ADDR_RXCTL;
    wr_mem = reg_wr && reg_addr == `MSC_ADDR_MEMCFG;
    nxt_s = s_ff;
    nxt_s.carrier_d = carrier_s_ff;

    // Configuration register survives soft reset
    if (wr_cfg) begin
      nxt_s.cfg = (reg_wdata & `MSC_CFG_WMASK) | (`MSC_CFG_RST & ~`MSC_CFG_WMASK);
    end

    // Transmit status flags
    if (tx_frame_start) begin
      nxt_s.ts_mult    = 1'b0;
      nxt_s.ts_success = 1'b0;
      // Collision flags drop once the packet before ended with success
      if (s_ff.ts_success) begin
        nxt_s.ts_sngl  = 1'b0;
        nxt_s.ts_multi = 1'b0;
      end
    end
    if (tx_enable_set) begin
      nxt_s.ts_success = 1'b0;
    end
    if (tx_frame_end) begin
      nxt_s.ts_mult    = tx_multicast;
      nxt_s.ts_success = ok_end;
      nxt_s.ts_excessive_deferral_flag = 1'b0;
      nxt_s.ts_defr    = 1'b0;
    end
    if (tx_collision) begin
      nxt_s.ts_sngl = 1'b1;
      if (col_cnt_ff != 3'h0) begin
        nxt_s.ts_multi = 1'b1;
      end
    end

    // Deferral detection
    if (tx_deferring) begin
      if (s_ff.defer_cyc != 32'hffffffff) begin
        nxt_s.defer_cyc = s_ff.defer_cyc + 32'h1;
      end
    end else begin
      nxt_s.defer_cyc = 32'h0;
    end
    if (s_ff.defer_cyc > 32'(EXCESSIVE_DEFERRAL_FLAG_CYCLES)) begin
      nxt_s.ts_excessive_deferral_flag = 1'b1;
    end
    if (tx_in_gap && carrier_s_ff) begin
      nxt_s.ts_defr = 1'b1;
    end

    // Statistics: read clears, later events still count
    if (stat_rd) begin
      nxt_s.cnt_exc = 4'h0;
      nxt_s.cnt_def = 4'h0;
      nxt_s.cnt_mul = 4'h0;
      nxt_s.cnt_sgl = 4'h0;
    end
    if (tx_frame_end) begin
      // Counting once per packet, on the updated value after clear
      if (ok_end && col_cnt_ff == 3'h1 && nxt_s.cnt_sgl != `MSC_STAT_SAT) begin
        nxt_s.cnt_sgl = nxt_s.cnt_sgl + 4'h1;
      end
      if (col_cnt_ff >= 3'h2 && nxt_s.cnt_mul != `MSC_STAT_SAT) begin
        nxt_s.cnt_mul = nxt_s.cnt_mul + 4'h1;
      end
      if ((s_ff.ts_defr || nxt_s.ts_defr) && nxt_s.cnt_def != `MSC_STAT_SAT) begin
        nxt_s.cnt_def = nxt_s.cnt_def + 4'h1;
      end
      if ((s_ff.ts_excessive_deferral_flag || nxt_s.ts_excessive_deferral_flag) && nxt_s.cnt_exc != `MSC_STAT_SAT) begin
        nxt_s.cnt_exc = nxt_s.cnt_exc + 4'h1;
      end
    end

    // Receive control; abort flag set wins over clear
    if (wr_rx) begin
      nxt_s.rxctl = reg_wdata & `MSC_RC_WMASK;
      if (!reg_wdata[`MSC_RC_ABORT]) begin
        nxt_s.rxctl[`MSC_RC_ABORT] = 1'b0;
      end else begin
        nxt_s.rxctl[`MSC_RC_ABORT] = s_ff.rxctl[`MSC_RC_ABORT];
      end
    end

    // Carrier filter: three nibble times before carrier counts
    if (!carrier_s_ff) begin
      nxt_s.filt_cnt = 2'h0;
      nxt_s.car_seen = 1'b0;
    end else if (!s_ff.rxctl[`MSC_RC_CAR_FILT]) begin
      nxt_s.car_seen = 1'b1;
    end else if (s_ff.filt_cnt == `MSC_FILT_NIBBLES) begin
      nxt_s.car_seen = 1'b1;
    end else begin
      nxt_s.filt_cnt = s_ff.filt_cnt + 2'h1;
    end

    // Receive frame tracking
    if (s_ff.car_seen && !s_ff.rx_active && s_ff.rxctl[`MSC_RC_RX_EN]) begin
      nxt_s.rx_active = 1'b1;
      nxt_s.rx_len    = 12'h0;
      nxt_s.rx_drop   = 1'b0;
    end
    if (s_ff.rx_active && rx_byte) begin
      if (s_ff.rx_len != 12'hfff) begin
        nxt_s.rx_len = s_ff.rx_len + 12'h1;
      end
      if (s_ff.rx_len >= `MSC_MAX_FRAME) begin
        nxt_s.rx_drop = 1'b1;
        nxt_s.rxctl[`MSC_RC_ABORT] = 1'b1;
      end
    end
    if (s_ff.rx_active && rx_frame_end) begin
      nxt_s.rx_active = 1'b0;
    end

    // Free memory tracking and reservation
    if (mmu_reset) begin
      nxt_s.free_mem = `MSC_MEM_SIZE_RST;
    end else if (mem_alloc && s_ff.free_mem != 8'h0) begin
      nxt_s.free_mem = s_ff.free_mem - 8'h1;
    end else if (mem_release && s_ff.free_mem != `MSC_MEM_SIZE_RST) begin
      nxt_s.free_mem = s_ff.free_mem + 8'h1;
    end
    if (wr_mem) begin
      nxt_s.tx_resv = reg_wdata[7:0];
    end

    // Read data, and wait states on each access unless no-wait is set
    nxt_s.rdata = 16'h0;
    if (reg_rd) begin
      case (reg_addr)
        `MSC_ADDR_CFG:     nxt_s.rdata = s_ff.cfg;
        `MSC_ADDR_TXST:    nxt_s.rdata = {8'h0, s_ff.ts_defr, s_ff.ts_excessive_deferral_flag, 2'h0,
                                          s_ff.ts_mult, s_ff.ts_multi, s_ff.ts_sngl,
                                          s_ff.ts_success};
        `MSC_ADDR_RXCTL:   nxt_s.rdata = s_ff.rxctl;
        `MSC_ADDR_STAT:    nxt_s.rdata = stat_word;
        `MSC_ADDR_MEMINFO: nxt_s.rdata = {`MSC_MEM_SIZE_RST, s_ff.free_mem};
        `MSC_ADDR_MEMCFG:  nxt_s.rdata = {4'h0, `MSC_MEM_MULT, 1'b0, s_ff.tx_resv};
        default:           nxt_s.rdata = 16'h0;
      endcase
    end
    if ((reg_rd || reg_wr) && !s_ff.cfg[`MSC_CFG_NO_WAIT]) begin
      nxt_s.wait_on  = 1'b1;
      nxt_s.wait_cnt = `MSC_WAIT_CLKS;
    end else if (s_ff.wait_on) begin
      if (s_ff.wait_cnt == 2'h1) begin
        nxt_s.wait_on = 1'b0;
      end
      nxt_s.wait_cnt = s_ff.wait_cnt - 2'h1;
    end

    // Soft reset clears transmit flags, counters, receive control, memory and rx_active
    if (soft_rst && !(wr_rx && !reg_wdata[`MSC_RC_SOFT_RST])) begin
      nxt_s.ts_success = 1'b0;
      nxt_s.ts_sngl    = 1'b0;
      nxt_s.ts_multi   = 1'b0;
      nxt_s.ts_mult    = 1'b0;
      nxt_s.ts_excessive_deferral_flag = 1'b0;
      nxt_s.ts_defr    = 1'b0;
      nxt_s.rxctl      = 16'h0;
      nxt_s.rxctl[`MSC_RC_SOFT_RST] = 1'b1;
      nxt_s.cnt_exc    = 4'h0;
      nxt_s.cnt_def    = 4'h0;
      nxt_s.cnt_mul    = 4'h0;
      nxt_s.cnt_sgl    = 4'h0;
      nxt_s.free_mem   = `MSC_MEM_SIZE_RST;
      nxt_s.tx_resv    = 8'h0;
      nxt_s.rx_active  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff          <= '0;
      s_ff.cfg      <= `MSC_CFG_RST;
      s_ff.free_mem <= `MSC_MEM_SIZE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata         = s_ff.rdata;
  assign io_ready          = !(s_ff.wait_on || reg_rd || reg_wr) ||
                             (s_ff.cfg[`MSC_CFG_NO_WAIT] && !data_reg_busy);
  assign rx_carrier        = s_ff.car_seen;
  assign crc_strip         = s_ff.rxctl[`MSC_RC_CRC_STRIP];
  assign soft_reset_active = soft_rst;
  assign rx_frame_drop     = s_ff.rx_drop;
  assign rx_accept = s_ff.rx_active && !s_ff.rx_drop &&
                     (!rx_own_frame || full_duplex) &&
                     (s_ff.rxctl[`MSC_RC_PROMISC] || rx_dest_match ||
                      (rx_dest_group && (s_ff.rxctl[`MSC_RC_ALLMULT] || rx_mcast_match)));
  assign rx_alloc_ok = rx_alloc_req &&
                       (s_ff.tx_resv == 8'h0 || s_ff.free_mem > s_ff.tx_resv);
  assign counter_rollover = (stat_word[3:0] == `MSC_STAT_SAT) ||
                            (stat_word[7:4] == `MSC_STAT_SAT) ||
                            (stat_word[11:8] == `MSC_STAT_SAT) ||
                            (stat_word[15:12] == `MSC_STAT_SAT);
  assign mii_select_pin        = s_ff.cfg[`MSC_CFG_PORT_SEL];
  assign full_step_pin_n       = !s_ff.cfg[`MSC_CFG_FULL_STEP];
  assign attachment_select_pin = s_ff.cfg[`MSC_CFG_ATT_SEL];

  // Interrupt pin routing, unselected pins released
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_int
      assign interrupt_out_oe[gi] = s_ff.cfg[`MSC_CFG_INT_LO +: 2] == 2'(gi);
      assign interrupt_out[gi]    = interrupt_out_oe[gi] && irq_event;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_stat_clear;
    @(posedge clk) disable iff (sys_rst)
      (stat_rd && !tx_frame_end && !soft_rst) |=> (stat_word == 16'h0);
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("stat not cleared");

  property p_stat_sat;
    @(posedge clk) disable iff (sys_rst)
      (s_ff.cnt_sgl == 4'hf && !stat_rd && !soft_rst) |=> (s_ff.cnt_sgl == 4'hf);
  endproperty
  a_stat_sat: assert property (p_stat_sat) else $error("counter wrapped");

  property p_mult_clear;
    @(posedge clk) disable iff (sys_rst)
      (tx_frame_start && !tx_frame_end) |=> !s_ff.ts_mult;
  endproperty
  a_mult_clear: assert property (p_mult_clear) else $error("multicast flag kept");

  property p_success;
    @(posedge clk) disable iff (sys_rst)
      (tx_frame_end && !soft_rst) |=> (s_ff.ts_success == !$past(tx_fatal));
  endproperty
  a_success: assert property (p_success) else $error("success flag wrong");

  property p_full_step;
    @(posedge clk) disable iff (sys_rst)
      full_step_pin_n != s_ff.cfg[`MSC_CFG_FULL_STEP];
  endproperty
  a_full_step: assert property (p_full_step) else $error("full step not inverted");

  property p_int_one;
    @(posedge clk) disable iff (sys_rst) $onehot(interrupt_out_oe);
  endproperty
  a_int_one: assert property (p_int_one) else $error("interrupt pin select");

  property p_resv;
    @(posedge clk) disable iff (sys_rst)
      (rx_alloc_req && s_ff.tx_resv != 8'h0 && s_ff.free_mem <= s_ff.tx_resv) |-> !rx_alloc_ok;
  endproperty
  a_resv: assert property (p_resv) else $error("reservation ignored");

  property p_wait;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd && !s_ff.cfg[`MSC_CFG_NO_WAIT]) |=> !io_ready ##1 !io_ready;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait states");

  property p_abort_sticky;
    @(posedge clk) disable iff (sys_rst)
      (s_ff.rxctl[`MSC_RC_ABORT] && !reg_wr && !soft_rst) |=> s_ff.rxctl[`MSC_RC_ABORT];
  endproperty
  a_abort_sticky: assert property (p_abort_sticky) else $error("abort flag lost");
endmodule
`default_nettype wire
